// File: inc/osw_pkg.sv
/*
  shared constants and types of the on/off switch controller.
  assumes a 125 MHz system clock.
*/
package osw_pkg;
    localparam int CLK_HZ = 125000000;
    localparam int CLK_MHZ = 125;
    localparam int F_NOM_HZ = 66000;
    localparam int F_JIT_PP_HZ = 4000;
    localparam int F_MOD_HZ = 1000;
    localparam int F_SS1_HZ = 16500;
    localparam int F_SS2_HZ = 22000;
    localparam int F_SS3_HZ = 33000;
    localparam int PER_W = 14;
    localparam int PER_NOM = CLK_HZ / F_NOM_HZ;
    localparam int PER_SS1_DEF = CLK_HZ / F_SS1_HZ;
    localparam int PER_SS2_DEF = CLK_HZ / F_SS2_HZ;
    localparam int PER_SS3_DEF = CLK_HZ / F_SS3_HZ;
    localparam int JIT_SPAN = CLK_HZ / (F_NOM_HZ - F_JIT_PP_HZ / 2)
                              - CLK_HZ / (F_NOM_HZ + F_JIT_PP_HZ / 2);
    localparam int JIT_STEPS = F_NOM_HZ / (2 * F_MOD_HZ);
    localparam int JIT_STEP = JIT_SPAN / JIT_STEPS;
    localparam int MS_CYC_DEF = CLK_HZ / 1000;
    localparam int FAULT_DETECT_WINDOW_MS = 50;
    localparam int RESTART_OFF_TIME_FIRST_MS = 150;
    localparam int RESTART_OFF_TIME_LATER_MS = 1500;
    localparam int SS_CYCLES = 256;
    localparam int SS_STEP1 = 85;
    localparam int SS_STEP2 = 170;
    localparam int LINE_OV_CYCLES = 2;
    localparam int BPSD_TICKS = 3;
    localparam int LIMIT_BLANKING_TIME_NS = 200;
    localparam int LEB_CYC = (LIMIT_BLANKING_TIME_NS * CLK_MHZ + 999) / 1000;
    // flag positions in the synchronised input vector
    localparam int FL_TRIP = 0;
    localparam int FL_LINEOV = 1;
    localparam int FL_BPSD = 2;
    localparam int FL_UNDER = 3;
    localparam int FL_FULL = 4;
    localparam int FL_ILIM = 5;
    localparam int FL_CAP = 6;
    localparam int NFLAGS = 7;
    // register map
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_STATUS = 12'h004;
    localparam logic [11:0] REG_IRQ_STAT = 12'h008;
    localparam logic [11:0] REG_IRQ_MASK = 12'h00c;
    localparam int CTRL_SW_EN = 0;
    localparam int CTRL_JIT_EN = 1;
    localparam logic [1:0] CTRL_RESET = 2'h3;
    localparam int IRQ_LINEOV = 0;
    localparam int IRQ_BPSD = 1;
    localparam int IRQ_WINDOW = 2;
    localparam int IRQ_UVLO = 3;
    localparam int IRQ_W = 4;
    localparam logic [1:0] SS_STAGE1 = 2'h0;
    localparam logic [1:0] SS_STAGE2 = 2'h1;
    localparam logic [1:0] SS_STAGE3 = 2'h2;
    localparam logic [1:0] SS_NOMINAL = 2'h3;
    typedef logic [1:0] osw_stage_t;
    typedef enum logic [3:0] {
        ST_POWERUP = 4'h1,
        ST_SOFT = 4'h2,
        ST_RUN = 4'h4,
        ST_OFF = 4'h8
    } osw_state_e;
endpackage

// File: inc/osw_core_if.sv
/*
  internal carrier between controller, oscillator and restart timer.
  assumes all three run on the same clock.
*/
`timescale 1ns/1ps
interface osw_core_if;
    import osw_pkg::*;
    logic cycleStart;
    logic maxDuty;
    logic jitterOn;
    osw_stage_t stage;
    logic msTick;
    logic offStart;
    logic offLong;
    logic offActive;
    modport osc (input stage, input jitterOn, output cycleStart, output maxDuty);
    modport tmr (input offStart, input offLong, output msTick, output offActive);
    modport ctl (output stage, output jitterOn, input cycleStart, input maxDuty,
                 output offStart, output offLong, input msTick, input offActive);
endinterface

// File: hdl/osw_oscillator.sv
/*
  cycle oscillator: cycle-start pulse, max duty window, jitter sweep.
  assumes stage and jitterOn come from the controller on the same clock.
*/
`timescale 1ns/1ps
module osw_oscillator
    import osw_pkg::*;
#(
    parameter int PER_SS1 = PER_SS1_DEF,
    parameter int PER_SS2 = PER_SS2_DEF,
    parameter int PER_SS3 = PER_SS3_DEF
) (
    input logic clock,
    input logic rst,
    osw_core_if.osc o
);
    typedef struct packed {
        logic [PER_W-1:0] phase;
        logic [PER_W-1:0] period;
        logic [7:0] jitOff;
        logic [7:0] jitCnt;
        logic jitUp;
        logic cycleStart;
        logic maxDuty;
    } osw_osc_s;

    osw_osc_s q;
    osw_osc_s n;

    always_comb begin
        n = q;
        n.cycleStart = 1'b0;
        if (q.phase >= q.period - PER_W'(1)) begin
            n.phase = '0;
            n.cycleStart = 1'b1;
            // sweep a triangle once per modulation period; it starts downward from zero, so the 8-bit offset wraps below it
            if (o.jitterOn) begin
                n.jitOff = q.jitUp ? q.jitOff + 8'(JIT_STEP) : q.jitOff - 8'(JIT_STEP);
                n.jitCnt = q.jitCnt + 8'h01;
                if (q.jitCnt == 8'(JIT_STEPS - 1)) begin
                    n.jitCnt = 8'h00;
                    n.jitUp = ~q.jitUp;
                end
            end
            case (o.stage)
                SS_STAGE1: n.period = PER_W'(PER_SS1);
                SS_STAGE2: n.period = PER_W'(PER_SS2);
                SS_STAGE3: n.period = PER_W'(PER_SS3);
                default: n.period = PER_W'(PER_NOM - JIT_SPAN / 2) + PER_W'(n.jitOff);
            endcase
        end else begin
            n.phase = q.phase + PER_W'(1);
        end
        // duty window ends at three quarters of the period
        n.maxDuty = n.phase < (q.period - (q.period >> 2));
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign o.cycleStart = q.cycleStart;
    assign o.maxDuty = q.maxDuty;
endmodule

// File: hdl/osw_restart_timer.sv
/*
  millisecond divider and auto-restart off-time counter.
  assumes offStart is a one-cycle pulse from the controller.
*/
`timescale 1ns/1ps
module osw_restart_timer
    import osw_pkg::*;
#(
    parameter int MS_CYC = MS_CYC_DEF
) (
    input logic clock,
    input logic rst,
    osw_core_if.tmr t
);
    typedef struct packed {
        logic [23:0] msCnt;
        logic msTick;
        logic [10:0] offCnt;
        logic offActive;
    } osw_tmr_s;

    osw_tmr_s q;
    osw_tmr_s n;

    always_comb begin
        n = q;
        n.msTick = 1'b0;
        if (q.msCnt == 24'(MS_CYC - 1)) begin
            n.msCnt = 24'h000000;
            n.msTick = 1'b1;
        end else begin
            n.msCnt = q.msCnt + 24'h000001;
        end
        if (t.offStart) begin
            n.offActive = 1'b1;
            n.offCnt = t.offLong ? 11'(RESTART_OFF_TIME_LATER_MS - 1)
                                 : 11'(RESTART_OFF_TIME_FIRST_MS - 1);
        end else if (q.offActive && q.msTick) begin
            if (q.offCnt == 11'h000) begin
                n.offActive = 1'b0;
            end else begin
                n.offCnt = q.offCnt - 11'h001;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign t.msTick = q.msTick;
    assign t.offActive = q.offActive;
endmodule

// File: hdl/osw_switch_controller.sv
/*
  on/off switch controller top: flag sync, per-cycle gate decision, soft-start,
  undervoltage lockout, fault paths into auto-restart, apb registers, interrupt.
  assumes comparator flags are asynchronous levels from the analogue front end
  and that reset is applied at power-up.
*/
// Implementation choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
module osw_switch_controller
    import osw_pkg::*;
#(
    parameter int PER_SS1 = PER_SS1_DEF,
    parameter int PER_SS2 = PER_SS2_DEF,
    parameter int PER_SS3 = PER_SS3_DEF,
    parameter int MS_CYC = MS_CYC_DEF,
    parameter logic LARGE_VARIANT = 1'b1
) (
    input logic clock,
    input logic rst,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [11:0] paddr,
    input logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input logic regulationTripCurrent,
    input logic lineOvervoltageCurrent,
    input logic bypassShutdownCurrent,
    input logic bypassBelowHysteresis,
    input logic bypassAtSupplyLevel,
    input logic currentLimitFlag,
    input logic bypassCapLarge,
    output logic gateEnable,
    output logic maxDutySignal,
    output logic cycleStart,
    output logic regulatorOn,
    output logic reducedLimit,
    output logic irq
);
    typedef struct packed {
        logic [NFLAGS-1:0] sy1;
        logic [NFLAGS-1:0] sy2;
        osw_state_e state;
        logic gate;
        logic sampledOn;
        logic limited;
        logic [5:0] lebCnt;
        logic ovSeen;
        logic [1:0] ovCnt;
        logic [1:0] sdCnt;
        logic uvLock;
        logic [8:0] ssCnt;
        osw_stage_t stage;
        logic [5:0] faultCnt;
        logic everFault;
        logic modeDone;
        logic reducedLimit;
        logic [1:0] ctrl;
        logic [IRQ_W-1:0] irqStat;
        logic [IRQ_W-1:0] irqMask;
        logic apbAck;
        logic [31:0] prdata;
        logic pslverr;
        logic offStart;
        logic offLong;
    } osw_ctl_s;

    osw_ctl_s q;
    osw_ctl_s n;
    osw_core_if core ();

    osw_oscillator #(
        .PER_SS1(PER_SS1),
        .PER_SS2(PER_SS2),
        .PER_SS3(PER_SS3)
    ) uOsc (
        .clock(clock),
        .rst(rst),
        .o(core)
    );

    osw_restart_timer #(
        .MS_CYC(MS_CYC)
    ) uTmr (
        .clock(clock),
        .rst(rst),
        .t(core)
    );

    logic [NFLAGS-1:0] flags;
    logic block;
    logic enableNow;
    logic lineFault;
    logic sdFault;
    logic windowFault;
    logic apbWrite;
    logic [IRQ_W-1:0] irqSet;
    logic [IRQ_W-1:0] irqClr;
    osw_stage_t startStage;

    assign flags = q.sy2;
    // skipped cycles count as regulation for soft-start and the fault window
    assign enableNow = ~flags[FL_TRIP];
    assign startStage = LARGE_VARIANT ? SS_STAGE1 : SS_STAGE3;
    assign block = q.uvLock | core.offActive | (q.state != ST_SOFT && q.state != ST_RUN)
                   | ~q.ctrl[CTRL_SW_EN] | ~q.modeDone | q.offStart;
    assign apbWrite = psel & penable & q.apbAck & pwrite;

    always_comb begin
        n = q;
        n.sy1 = {bypassCapLarge, currentLimitFlag, bypassAtSupplyLevel,
                 bypassBelowHysteresis, bypassShutdownCurrent,
                 lineOvervoltageCurrent, regulationTripCurrent};
        n.sy2 = q.sy1;
        n.offStart = 1'b0;
        lineFault = 1'b0;
        sdFault = 1'b0;
        windowFault = 1'b0;
        irqSet = '0;
        irqClr = '0;

        // lockout below the low threshold, release only at full level
        if (flags[FL_UNDER]) begin
            n.uvLock = 1'b1;
            irqSet[IRQ_UVLO] = ~q.uvLock;
        end else if (flags[FL_FULL]) begin
            n.uvLock = 1'b0;
        end

        // capacitor size is judged once; later changes are ignored
        if (!q.modeDone && core.cycleStart) begin
            n.reducedLimit = flags[FL_CAP];
            n.modeDone = 1'b1;
        end

        // shutdown current must stay high across consecutive cycle starts
        if (!flags[FL_BPSD]) begin
            n.sdCnt = 2'h0;
        end else if (core.cycleStart) begin
            if (q.sdCnt == 2'(BPSD_TICKS - 1)) begin
                sdFault = 1'b1;
                n.sdCnt = 2'h0;
            end else begin
                n.sdCnt = q.sdCnt + 2'h1;
            end
        end

        if (core.cycleStart) begin
            // overvoltage must be seen in consecutive enabled cycles
            if (q.sampledOn && q.ovSeen) begin
                if (q.ovCnt == 2'(LINE_OV_CYCLES - 1)) begin
                    lineFault = 1'b1;
                    n.ovCnt = 2'h0;
                end else begin
                    n.ovCnt = q.ovCnt + 2'h1;
                end
            end else begin
                n.ovCnt = 2'h0;
            end
            n.sampledOn = enableNow & ~block;
            n.lebCnt = 6'h00;
            n.limited = 1'b0;
            n.ovSeen = 1'b0;
            if (q.state == ST_SOFT) begin
                n.ssCnt = q.ssCnt + 9'h001;
                if (LARGE_VARIANT && q.ssCnt == 9'(SS_STEP1)) begin
                    n.stage = SS_STAGE2;
                end else if (LARGE_VARIANT && q.ssCnt == 9'(SS_STEP2)) begin
                    n.stage = SS_STAGE3;
                end
                if (q.ssCnt == 9'(SS_CYCLES - 1) || !enableNow) begin
                    n.state = ST_RUN;
                    n.stage = SS_NOMINAL;
                end
            end
        end else begin
            n.ovSeen = q.ovSeen | (flags[FL_LINEOV] & q.gate);
            if (q.gate && q.lebCnt != 6'(LEB_CYC)) begin
                n.lebCnt = q.lebCnt + 6'h01;
            end
            if (q.gate && q.lebCnt == 6'(LEB_CYC) && flags[FL_ILIM]) begin
                n.limited = 1'b1;
            end
        end

        // fault window: any skipped cycle clears it
        if (!enableNow) begin
            n.faultCnt = 6'h00;
            n.everFault = q.state == ST_OFF ? q.everFault : 1'b0;
        end else if (core.msTick && (q.state == ST_SOFT || q.state == ST_RUN)) begin
            if (q.faultCnt == 6'(FAULT_DETECT_WINDOW_MS - 1)) begin
                windowFault = 1'b1;
                n.faultCnt = 6'h00;
            end else begin
                n.faultCnt = q.faultCnt + 6'h01;
            end
        end

        case (q.state)
            ST_POWERUP: begin
                if (q.modeDone && !q.uvLock) begin
                    n.state = ST_SOFT;
                    n.ssCnt = 9'h000;
                    n.stage = startStage;
                end
            end
            ST_SOFT, ST_RUN: begin
                if (lineFault || sdFault || windowFault) begin
                    n.state = ST_OFF;
                    n.offStart = 1'b1;
                    n.offLong = q.everFault;
                    n.everFault = 1'b1;
                    n.sampledOn = 1'b0;
                    n.faultCnt = 6'h00;
                    n.ovCnt = 2'h0;
                    n.stage = SS_NOMINAL;
                end
            end
            ST_OFF: begin
                // the timer raises its busy flag one cycle after the start pulse
                if (!q.offStart && !core.offActive) begin
                    n.state = ST_SOFT;
                    n.ssCnt = 9'h000;
                    n.stage = startStage;
                end
            end
            default: begin
                n.state = ST_POWERUP;
            end
        endcase
        irqSet[IRQ_LINEOV] = lineFault;
        irqSet[IRQ_BPSD] = sdFault;
        irqSet[IRQ_WINDOW] = windowFault;

        // gate holds the sampled decision; only the current limit, a fault or blocking terms may end it early
        n.gate = n.sampledOn & core.maxDuty & ~n.limited & ~block;

        // apb: first access cycle loads read data, second completes
        n.apbAck = 1'b0;
        if (psel && penable && !q.apbAck) begin
            n.apbAck = 1'b1;
            n.pslverr = 1'b0;
            n.prdata = 32'h00000000;
            if (paddr == REG_CTRL) begin
                n.prdata = 32'(q.ctrl);
            end else if (paddr == REG_STATUS) begin
                n.prdata = 32'({q.stage, q.reducedLimit, q.state == ST_SOFT,
                                core.offActive, q.uvLock, q.gate});
            end else if (paddr == REG_IRQ_STAT) begin
                n.prdata = 32'(q.irqStat);
            end else if (paddr == REG_IRQ_MASK) begin
                n.prdata = 32'(q.irqMask);
            end else begin
                n.pslverr = 1'b1;
            end
        end
        if (apbWrite) begin
            if (paddr == REG_CTRL) begin
                n.ctrl = pwdata[1:0];
            end else if (paddr == REG_IRQ_STAT) begin
                irqClr = pwdata[IRQ_W-1:0];
            end else if (paddr == REG_IRQ_MASK) begin
                n.irqMask = pwdata[IRQ_W-1:0];
            end
        end
        // a new event beats a simultaneous clear
        n.irqStat = (q.irqStat & ~irqClr) | irqSet;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            q <= '0;
            q.state <= ST_POWERUP;
            q.uvLock <= 1'b1;
            q.stage <= SS_NOMINAL;
            q.ctrl <= CTRL_RESET;
        end else begin
            q <= n;
        end
    end

    assign core.stage = q.stage;
    assign core.jitterOn = q.ctrl[CTRL_JIT_EN] & (q.stage == SS_NOMINAL);
    assign core.offStart = q.offStart;
    assign core.offLong = q.offLong;

    assign gateEnable = q.gate;
    // charging from the drain only while the switch is open
    assign regulatorOn = ~q.gate;
    assign maxDutySignal = core.maxDuty;
    assign cycleStart = core.cycleStart;
    assign reducedLimit = q.reducedLimit;
    assign irq = |(q.irqStat & q.irqMask);
    assign prdata = q.prdata;
    assign pslverr = q.pslverr & psel & penable & q.apbAck;
    assign pready = psel & penable & q.apbAck;
endmodule

// File: bench/osw_properties.sv
/*
  port checker for the on/off switch controller, bound to its top.
  assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module osw_checker
    import osw_pkg::*;
(
    input logic clock,
    input logic rst,
    input logic psel,
    input logic penable,
    input logic pready,
    input logic regulationTripCurrent,
    input logic bypassBelowHysteresis,
    input logic currentLimitFlag,
    input logic gateEnable,
    input logic maxDutySignal,
    input logic cycleStart,
    input logic regulatorOn,
    input logic reducedLimit
);
    logic [7:0] onCnt;
    logic [7:0] next_onCnt;
    // saturating, so a long pulse never wraps into a false short one
    always_comb begin
        next_onCnt = 8'h0;
        if (gateEnable) begin
            next_onCnt = (onCnt == 8'hff) ? onCnt : onCnt + 8'h1;
        end
    end
    always_ff @(posedge clock) begin
        onCnt <= rst ? 8'h0 : next_onCnt;
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    a_regulator_off_phase: assert property (regulatorOn == !gateEnable)
        else $error("regulator on while switch conducts");
    a_gate_at_start: assert property ($rose(gateEnable) |-> $past(cycleStart))
        else $error("gate rose away from a cycle start");
    a_start_one_pulse: assert property (cycleStart |=> !cycleStart)
        else $error("cycle start longer than one clock");
    a_trip_skips: assert property ((regulationTripCurrent [*4] ##0 cycleStart) |=> !gateEnable)
        else $error("gate on in a tripped cycle");
    a_duty_ends_gate: assert property ($fell(maxDutySignal) |=> !gateEnable)
        else $error("gate outlived max duty");
    a_limit_cuts: assert property ((currentLimitFlag [*3] ##0 onCnt > LEB_CYC + 2) |-> ##[1:2] !gateEnable)
        else $error("gate not cut by current limit");
    a_uv_blocks: assert property (bypassBelowHysteresis [*6] |-> !gateEnable)
        else $error("gate on under bypass undervoltage");
    a_limit_mode_held: assert property (reducedLimit |=> reducedLimit)
        else $error("limit mode changed after latching");
    a_one_wait_state: assert property ($rose(psel && penable) |-> !pready ##1 pready)
        else $error("apb answer not after one wait state");
endmodule
bind osw_switch_controller osw_checker u_chk (.clock(clock), .rst(rst), .psel(psel),
    .penable(penable), .pready(pready), .regulationTripCurrent(regulationTripCurrent),
    .bypassBelowHysteresis(bypassBelowHysteresis), .currentLimitFlag(currentLimitFlag),
    .gateEnable(gateEnable), .maxDutySignal(maxDutySignal), .cycleStart(cycleStart),
    .regulatorOn(regulatorOn), .reducedLimit(reducedLimit));

// File: bench/osw_plant_model.sv
/*
  far side: output filter with feedback divider, bypass capacitor, switch current.
  assumes the bench steers faults through the control inputs.
*/
`timescale 1ns/1ps
module osw_plant_model (
    input logic clock,
    input logic gateEnable,
    input logic regulatorOn,
    input logic [1:0] tripMode,
    input logic lineOv,
    input logic bpsd,
    input logic uvDrop,
    input logic limitOn,
    output logic regulationTripCurrent,
    output logic lineOvervoltageCurrent,
    output logic bypassShutdownCurrent,
    output logic bypassBelowHysteresis,
    output logic bypassAtSupplyLevel,
    output logic currentLimitFlag
);
    logic [9:0] vout = 10'h0;
    logic [2:0] dec = 3'h0;
    logic [5:0] chg = 6'h0;
    logic [6:0] onCnt = 7'h0;
    always @(posedge clock) begin
        dec <= dec + 3'h1;
        if (gateEnable && vout != 10'h3ff) begin
            vout <= vout + 10'h1;
        end else if (!gateEnable && dec == 3'h0 && vout != 10'h0) begin
            vout <= vout - 10'h1;
        end
        onCnt <= (gateEnable && onCnt != 7'h7f) ? onCnt + 7'h1 : (gateEnable ? onCnt : 7'h0);
        // capacitor charges only while the switch is off
        if (uvDrop) begin
            chg <= 6'h0;
        end else if (regulatorOn && chg != 6'h3f) begin
            chg <= chg + 6'h1;
        end
    end
    // mode 0 follows the output, 1 and 2 pin the divider high or low
    assign regulationTripCurrent = tripMode == 2'h1 || (tripMode == 2'h0 && vout > 10'h258);
    assign lineOvervoltageCurrent = lineOv;
    assign bypassShutdownCurrent = bpsd;
    assign bypassBelowHysteresis = uvDrop;
    assign bypassAtSupplyLevel = !uvDrop && chg == 6'h3f;
    assign currentLimitFlag = limitOn && onCnt > 7'h28;
endmodule

// File: bench/tb_top.sv
/*
  self-checking bench: apb master, plant model, fault sequences.
  assumes the checker is bound to the controller top.
*/
`timescale 1ns/1ps
module tb_top
    import osw_pkg::*;
;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic [31:0] q;
    logic pready, pslverr, gateEnable, maxDutySignal, cycleStart, regulatorOn, reducedLimit, irq;
    logic regulationTripCurrent, lineOvervoltageCurrent, bypassShutdownCurrent;
    logic bypassBelowHysteresis, bypassAtSupplyLevel, currentLimitFlag;
    logic [1:0] tripMode = 2'h2;
    logic lineOv = 1'b1, bpsd = 1'b0, uvDrop = 1'b0, limitOn = 1'b0, capLarge = 1'b0;
    logic e;
    logic gPrev = 1'b0;
    int n_mismatch = 0;
    int cmp_count = 0;
    int nRise = 0;
    int n0;
    int seed;
    // short counts keep off-times at 15000 clocks and the whole run under 100k
    osw_switch_controller #(.PER_SS1(250), .PER_SS2(200), .PER_SS3(150), .MS_CYC(100),
        .LARGE_VARIANT(1'b1)) u_dut (.clock, .rst, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .regulationTripCurrent, .lineOvervoltageCurrent,
        .bypassShutdownCurrent, .bypassBelowHysteresis, .bypassAtSupplyLevel,
        .currentLimitFlag, .bypassCapLarge(capLarge), .gateEnable, .maxDutySignal,
        .cycleStart, .regulatorOn, .reducedLimit, .irq);
    osw_plant_model u_plant (.clock, .gateEnable, .regulatorOn, .tripMode, .lineOv, .bpsd,
        .uvDrop, .limitOn, .regulationTripCurrent, .lineOvervoltageCurrent,
        .bypassShutdownCurrent, .bypassBelowHysteresis, .bypassAtSupplyLevel,
        .currentLimitFlag);
    initial begin
        forever #4 clock = ~clock;
    end
    always @(posedge clock) begin
        gPrev <= gateEnable;
        if (gateEnable === 1'b1 && gPrev === 1'b0) begin
            nRise <= nRise + 1;
        end
    end
    task automatic wrap_up();
        $display("counts: %0d compares, %0d mismatches", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic chk1(input string what, input logic exp, input logic got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %b, seen %b", what, exp, got);
        end
    endtask
    task automatic bail(input string what);
        n_mismatch++;
        $display("unexpected %s: expected completion, seen timeout", what);
        wrap_up();
    endtask
    // holds the request until pready is seen high at an edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            bail("apb answer");
        end
        @(posedge clock);
    endtask
    task automatic wait_bit(input logic [11:0] a, input int b, input logic v, input int lim);
        int n = 0;
        do begin
            apb(1'b0, a, 32'h0);
            n++;
        end while (q[b] !== v && n < lim);
        if (q[b] !== v) begin
            bail("register bit");
        end
    endtask
    // off-time must still be running 13000 clocks in, then end within 2000 status reads
    task automatic off_span();
        repeat (13000) @(posedge clock);
        apb(1'b0, REG_STATUS, 32'h0);
        chk1("off still active", 1'b1, q[2]);
        wait_bit(REG_STATUS, 2, 1'b0, 2000);
    endtask
    initial begin
        seed = 32'hcfd2;
        capLarge = 1'(($random(seed)));
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        apb(1'b0, REG_CTRL, 32'h0);
        chk("ctrl reset", 32'h3, q);
        apb(1'b0, REG_IRQ_STAT, 32'h0);
        chk("irq status reset", 32'h0, q);
        apb(1'b1, 12'h010, 32'hffffffff);
        chk1("unmapped write error", 1'b1, e);
        apb(1'b0, 12'h010, 32'h0);
        chk("unmapped read", 32'h0, q);
        apb(1'b1, REG_IRQ_MASK, 32'hf);
        apb(1'b0, REG_IRQ_MASK, 32'h0);
        chk("mask readback", 32'hf, q);
        $display("test registers done");
        wait_bit(REG_IRQ_STAT, IRQ_LINEOV, 1'b1, 6000);
        chk("fault cause", 32'h1, q & 32'h7);
        chk1("irq raised", 1'b1, irq);
        apb(1'b0, REG_STATUS, 32'h0);
        chk("gate and off bits", 32'h4, q & 32'h5);
        chk1("limit mode bit", capLarge, q[4]);
        chk1("limit mode port", capLarge, reducedLimit);
        lineOv <= 1'b0;
        tripMode <= 2'h0;
        apb(1'b1, REG_IRQ_STAT, 32'hf);
        apb(1'b0, REG_IRQ_STAT, 32'h0);
        chk("irq status cleared", 32'h0, q);
        chk1("irq dropped", 1'b0, irq);
        off_span();
        apb(1'b0, REG_STATUS, 32'h0);
        chk("soft-start stage", 32'h8, q & 32'h68);
        wait_bit(REG_STATUS, 3, 1'b0, 3000);
        apb(1'b0, REG_STATUS, 32'h0);
        chk("nominal stage", 32'h3, 32'(q[6:5]));
        $display("test line overvoltage done");
        tripMode <= 2'h1;
        repeat (20) @(posedge clock);
        n0 = nRise;
        repeat (4000) @(posedge clock);
        chk("rises while tripped", 32'(n0), 32'(nRise));
        tripMode <= 2'h2;
        n0 = 0;
        while (gateEnable !== 1'b1 && n0 < 4000) begin
            @(posedge clock);
            n0++;
        end
        if (gateEnable !== 1'b1) begin
            bail("gate rise");
        end
        repeat (1 + ($random(seed) & 15)) @(posedge clock);
        tripMode <= 2'h1;
        repeat (8) @(posedge clock);
        chk1("gate held mid-cycle", 1'b1, gateEnable);
        $display("test cycle decision done");
        tripMode <= 2'h2;
        wait_bit(REG_IRQ_STAT, IRQ_WINDOW, 1'b1, 3000);
        chk("fault cause", 32'h4, q & 32'h7);
        tripMode <= 2'h0;
        apb(1'b1, REG_IRQ_STAT, 32'hf);
        off_span();
        wait_bit(REG_STATUS, 3, 1'b0, 3000);
        $display("test fault window done");
        bpsd <= 1'b1;
        wait_bit(REG_IRQ_STAT, IRQ_BPSD, 1'b1, 3000);
        apb(1'b0, REG_STATUS, 32'h0);
        chk("gate and off bits", 32'h4, q & 32'h5);
        bpsd <= 1'b0;
        apb(1'b1, REG_IRQ_STAT, 32'hf);
        off_span();
        $display("test bypass shutdown done");
        uvDrop <= 1'b1;
        wait_bit(REG_STATUS, 1, 1'b1, 100);
        chk1("gate in lockout", 1'b0, gateEnable);
        apb(1'b0, REG_IRQ_STAT, 32'h0);
        chk1("undervoltage event", 1'b1, q[IRQ_UVLO]);
        uvDrop <= 1'b0;
        apb(1'b0, REG_STATUS, 32'h0);
        chk1("lock before full level", 1'b1, q[1]);
        wait_bit(REG_STATUS, 1, 1'b0, 200);
        $display("test undervoltage done");
        limitOn <= 1'b1;
        repeat (6000) @(posedge clock);
        $display("test current limit done");
        wrap_up();
    end
endmodule
